//--- rtl/tpm_top.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: Mode field picks two 8-bit, 16-bit, pattern, PWM
// R2: PWM period codes give 64, 128, 256
// R3: Pair 4/5 lower: external, tap 1, 4, 16
// R4: Upper: lower match, tap 1, 16, 256
// R5: 16-bit mode: upper counts lower overflow
// R6: Pair 6/7 lower code 00 never programmed
// R7: Pair 6/7 upper selects like pair 4/5
// R8: Action field inverts, sets, clears, or keeps
// R9: Enabled toggle follows selected timer's signal
// R10: Toggle source honoured only in 8-bit mode
// R11: Software writes flop control without read-modify-write
// R12: Flop control bits 4 to 6 unspecified
// R13: One action per write, toggles continue after
module tpm_top #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Count sources, bit 0 pair 4/5, bit 1 pair 6/7
    input  wire logic              prescale_tap_1,
    input  wire logic              prescale_tap_4,
    input  wire logic              prescale_tap_16,
    input  wire logic              prescale_tap_256,
    input  wire logic              ext_count_input_four,
    input  wire logic [1:0]        lower_match_pulse,
    input  wire logic [1:0]        lower_ovf_pulse,
    // Flop toggle sources
    input  wire logic [1:0]        pair01_mode,
    input  wire logic              timer_unit_zero,
    input  wire logic              timer_unit_one,
    // Count enables
    output logic [1:0]             lower_count_en,
    output logic [1:0]             upper_count_en,
    // Mode decode
    output logic [1:0]             pair_split_q,
    output logic [1:0]             pair_cascade_q,
    output logic [1:0]             pair_ppg_q,
    output logic [1:0]             pair_pwm_q,
    output logic [1:0][8:0]        pwm_period_q,
    // Timer flip-flop
    output logic                   timer_flop_one
);

    if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must be 12 to 32");
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [1:0][7:0]    mod_q;
    logic [1:0]         ff_act_q;
    logic               ff_ie_q;
    logic               ff_is_q;

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    logic               aw_full_q;
    logic               w_full_q;
    logic [ADDR_W-1:0]  waddr_q;
    logic [7:0]         wbyte_q;
    logic               wstrb0_q;
    logic               wr_fire;
    logic [9:0]         widx;
    logic               wmapped;
    logic               ff_we;

    assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
    assign widx    = waddr_q[11:2];
    assign wmapped = (widx == tpm_pkg::TPM_IDX_FLOP1) || (widx == tpm_pkg::TPM_IDX_P45) ||
                     (widx == tpm_pkg::TPM_IDX_P67);
    assign ff_we   = wr_fire && wstrb0_q && (widx == tpm_pkg::TPM_IDX_FLOP1);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            waddr_q       <= '0;
            wbyte_q       <= 8'h00;
            wstrb0_q      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= tpm_pkg::TPM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q     <= 1'b1;
                waddr_q       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q     <= 1'b1;
                wbyte_q      <= s_axi_wdata[7:0];
                wstrb0_q     <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wmapped ? tpm_pkg::TPM_RESP_OKAY : tpm_pkg::TPM_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_full_q     <= 1'b0;
                w_full_q      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mod_q[0] <= tpm_pkg::TPM_MODREG_RST;
            mod_q[1] <= tpm_pkg::TPM_MODREG_RST;
        end else if (wr_fire && wstrb0_q) begin
            if (widx == tpm_pkg::TPM_IDX_P45) begin
                mod_q[0] <= wbyte_q;
            end
            if (widx == tpm_pkg::TPM_IDX_P67) begin
                mod_q[1] <= wbyte_q;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ff_act_q <= tpm_pkg::TPM_FF_ACT_RST;
            ff_ie_q  <= 1'b0;
            ff_is_q  <= 1'b0;
        end else if (ff_we) begin
            ff_act_q <= wbyte_q[tpm_pkg::TPM_FF_ACT_LSB +: 2];
            ff_ie_q  <= wbyte_q[tpm_pkg::TPM_FF_IE_BIT];
            ff_is_q  <= wbyte_q[tpm_pkg::TPM_FF_IS_BIT];
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    logic [9:0]  ridx;
    logic [7:0]  rbyte;
    logic        rmapped;

    assign ridx = s_axi_araddr[11:2];

    // R12: bits 4 to 6 read zero
    always_comb begin
        rmapped = 1'b1;
        case (ridx)
            tpm_pkg::TPM_IDX_FLOP1: rbyte = {4'h0, ff_act_q, ff_ie_q, ff_is_q};
            tpm_pkg::TPM_IDX_P45:   rbyte = mod_q[0];
            tpm_pkg::TPM_IDX_P67:   rbyte = mod_q[1];
            default: begin
                rbyte   = 8'h00;
                rmapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= tpm_pkg::TPM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, rbyte};
            s_axi_rresp   <= rmapped ? tpm_pkg::TPM_RESP_OKAY : tpm_pkg::TPM_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------
    // Per-pair decode and clock selection
    // ----------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_pair
        logic [1:0] mode;
        logic [1:0] pcode;
        assign mode  = mod_q[g][tpm_pkg::TPM_MODE_LSB +: 2];
        assign pcode = mod_q[g][tpm_pkg::TPM_PWM_LSB +: 2];

        // R1: mode decode
        // R2: PWM period decode
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                pair_split_q[g]   <= 1'b1;
                pair_cascade_q[g] <= 1'b0;
                pair_ppg_q[g]     <= 1'b0;
                pair_pwm_q[g]     <= 1'b0;
                pwm_period_q[g]   <= tpm_pkg::TPM_PLEN_0;
            end else begin
                pair_split_q[g]   <= mode == tpm_pkg::TPM_MODE_8BIT;
                pair_cascade_q[g] <= mode == tpm_pkg::TPM_MODE_16BIT;
                pair_ppg_q[g]     <= mode == tpm_pkg::TPM_MODE_PPG;
                pair_pwm_q[g]     <= mode == tpm_pkg::TPM_MODE_PWM;
                if (mode != tpm_pkg::TPM_MODE_PWM) begin
                    pwm_period_q[g] <= tpm_pkg::TPM_PLEN_0;
                end else begin
                    case (pcode)
                        tpm_pkg::TPM_PWM_P64:  pwm_period_q[g] <= tpm_pkg::TPM_PLEN_64;
                        tpm_pkg::TPM_PWM_P128: pwm_period_q[g] <= tpm_pkg::TPM_PLEN_128;
                        tpm_pkg::TPM_PWM_P256: pwm_period_q[g] <= tpm_pkg::TPM_PLEN_256;
                        default:               pwm_period_q[g] <= tpm_pkg::TPM_PLEN_0;
                    endcase
                end
            end
        end

        // R3: pair 4/5 lower external
        // R7: pair 6/7 same upper mux
        tpm_clk_sel #(
            .LOWER_EXT (g == 0)
        ) u_clk_sel (
            .clk         (clk),
            .sys_rst     (sys_rst),
            .mode        (mode),
            .lower_sel   (mod_q[g][tpm_pkg::TPM_LCLK_LSB +: 2]),
            .upper_sel   (mod_q[g][tpm_pkg::TPM_UCLK_LSB +: 2]),
            .ext_count   (ext_count_input_four),
            .tap_1       (prescale_tap_1),
            .tap_4       (prescale_tap_4),
            .tap_16      (prescale_tap_16),
            .tap_256     (prescale_tap_256),
            .lower_match (lower_match_pulse[g]),
            .lower_ovf   (lower_ovf_pulse[g]),
            .lower_en_q  (lower_count_en[g]),
            .upper_en_q  (upper_count_en[g])
        );
    end

    // ----------------------------------------
    // Timer flip-flop one
    // ----------------------------------------
    // R13: action on the edge that raises the write response, one cycle after both channels are accepted
    tpm_flop u_flop (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .act_we       (ff_we),
        .act_code     (wbyte_q[tpm_pkg::TPM_FF_ACT_LSB +: 2]),
        .toggle_en    (ff_ie_q),
        .toggle_src   (ff_is_q),
        .pair01_mode  (pair01_mode),
        .timer0_pulse (timer_unit_zero),
        .timer1_pulse (timer_unit_one),
        .flop_q       (timer_flop_one)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_pwm_period: assert property ( // R2
        mod_q[0][7:4] == {tpm_pkg::TPM_MODE_PWM, tpm_pkg::TPM_PWM_P64}
        |=> pwm_period_q[0] == tpm_pkg::TPM_PLEN_64)
        else $error("PWM period 64 not decoded");
    chk_mode_cascade: assert property ( // R1
        mod_q[1][7:6] == tpm_pkg::TPM_MODE_16BIT |=> pair_cascade_q[1] && !pair_split_q[1])
        else $error("16-bit mode not decoded");
    chk_rd_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    chk_write_answer: assert property (
        aw_full_q && w_full_q && !s_axi_bvalid |=> s_axi_bvalid)
        else $error("write response late");
    cov_pwm_write: cover property (wr_fire && widx == tpm_pkg::TPM_IDX_P45 ##2 pair_pwm_q[0]);
    cov_read: cover property (s_axi_rvalid && s_axi_rready);

endmodule
`default_nettype wire

//--- rtl/tpm_pkg.sv
package tpm_pkg;

    // ----------------------------------------
    // Register indices (byte address = index * 4)
    // ----------------------------------------
    localparam logic [9:0] TPM_IDX_FLOP1 = 10'h105;
    localparam logic [9:0] TPM_IDX_P45   = 10'h114;
    localparam logic [9:0] TPM_IDX_P67   = 10'h11C;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int unsigned TPM_MODE_LSB   = 6;
    localparam int unsigned TPM_PWM_LSB    = 4;
    localparam int unsigned TPM_UCLK_LSB   = 2;
    localparam int unsigned TPM_LCLK_LSB   = 0;
    localparam int unsigned TPM_FF_ACT_LSB = 2;
    localparam int unsigned TPM_FF_IE_BIT  = 1;
    localparam int unsigned TPM_FF_IS_BIT  = 0;
    localparam logic [7:0]  TPM_MODREG_RST = 8'h00;
    localparam logic [1:0]  TPM_FF_ACT_RST = 2'h3;
    localparam logic        TPM_FLOP_RST   = 1'b0;

    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    typedef enum logic [1:0] {
        TPM_MODE_8BIT  = 2'b00,
        TPM_MODE_16BIT = 2'b01,
        TPM_MODE_PPG   = 2'b10,
        TPM_MODE_PWM   = 2'b11
    } tpm_mode_t;

    typedef enum logic [1:0] {
        TPM_FF_INVERT = 2'b00,
        TPM_FF_SET    = 2'b01,
        TPM_FF_CLEAR  = 2'b10,
        TPM_FF_KEEP   = 2'b11
    } tpm_ffact_t;

    localparam logic [1:0] TPM_LCLK_EXT   = 2'b00;
    localparam logic [1:0] TPM_LCLK_T1    = 2'b01;
    localparam logic [1:0] TPM_LCLK_T4    = 2'b10;
    localparam logic [1:0] TPM_LCLK_T16   = 2'b11;
    localparam logic [1:0] TPM_UCLK_MATCH = 2'b00;
    localparam logic [1:0] TPM_UCLK_T1    = 2'b01;
    localparam logic [1:0] TPM_UCLK_T16   = 2'b10;
    localparam logic [1:0] TPM_UCLK_PRESCALE_TAP_256  = 2'b11;

    localparam logic [1:0] TPM_PWM_RSVD = 2'b00;
    localparam logic [1:0] TPM_PWM_P64  = 2'b01;
    localparam logic [1:0] TPM_PWM_P128 = 2'b10;
    localparam logic [1:0] TPM_PWM_P256 = 2'b11;
    localparam logic [8:0] TPM_PLEN_64  = 9'h040;
    localparam logic [8:0] TPM_PLEN_128 = 9'h080;
    localparam logic [8:0] TPM_PLEN_256 = 9'h100;
    localparam logic [8:0] TPM_PLEN_0   = 9'h000;

    localparam logic [1:0] TPM_RESP_OKAY   = 2'b00;
    localparam logic [1:0] TPM_RESP_SLVERR = 2'b10;

endpackage

//--- rtl/tpm_clk_sel.sv
`timescale 1ns/1ps
`default_nettype none
module tpm_clk_sel #(
    parameter bit LOWER_EXT = 1'b1
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Configuration
    input  wire logic [1:0] mode,
    input  wire logic [1:0] lower_sel,
    input  wire logic [1:0] upper_sel,
    // Count sources
    input  wire logic       ext_count,
    input  wire logic       tap_1,
    input  wire logic       tap_4,
    input  wire logic       tap_16,
    input  wire logic       tap_256,
    input  wire logic       lower_match,
    input  wire logic       lower_ovf,
    // Count enables
    output logic            lower_en_q,
    output logic            upper_en_q
);

    logic lower_en_d;
    logic upper_en_d;

    // ----------------------------------------
    // Lower timer source
    // ----------------------------------------
    // R3: lower source mux
    always_comb begin
        case (lower_sel)
            tpm_pkg::TPM_LCLK_EXT: lower_en_d = LOWER_EXT ? ext_count : 1'b0;
            tpm_pkg::TPM_LCLK_T1:  lower_en_d = tap_1;
            tpm_pkg::TPM_LCLK_T4:  lower_en_d = tap_4;
            tpm_pkg::TPM_LCLK_T16: lower_en_d = tap_16;
            default:               lower_en_d = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Upper timer source
    // ----------------------------------------
    // R4: upper source mux
    always_comb begin
        case (upper_sel)
            tpm_pkg::TPM_UCLK_MATCH: upper_en_d = lower_match;
            tpm_pkg::TPM_UCLK_T1:    upper_en_d = tap_1;
            tpm_pkg::TPM_UCLK_T16:   upper_en_d = tap_16;
            tpm_pkg::TPM_UCLK_PRESCALE_TAP_256:  upper_en_d = tap_256;
            default:                 upper_en_d = 1'b0;
        endcase
        // R5: cascade overrides field
        if (mode == tpm_pkg::TPM_MODE_16BIT) begin
            upper_en_d = lower_ovf;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lower_en_q <= 1'b0;
            upper_en_q <= 1'b0;
        end else begin
            lower_en_q <= lower_en_d;
            upper_en_q <= upper_en_d;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_lower_tap4: assert property ( // R3
        lower_sel == tpm_pkg::TPM_LCLK_T4 |=> lower_en_q == $past(tap_4))
        else $error("lower enable does not follow tap 4");
    chk_lower_reserved: assert property ( // R6
        !LOWER_EXT && lower_sel == tpm_pkg::TPM_LCLK_EXT |=> !lower_en_q)
        else $error("reserved lower code produced a count");
    chk_upper_match: assert property ( // R4
        mode != tpm_pkg::TPM_MODE_16BIT && upper_sel == tpm_pkg::TPM_UCLK_MATCH && lower_match
        |=> upper_en_q)
        else $error("upper enable missed lower match");
    chk_upper_cascade: assert property ( // R5
        mode == tpm_pkg::TPM_MODE_16BIT |=> upper_en_q == $past(lower_ovf))
        else $error("cascade upper enable not from overflow");
    chk_upper_tap256: assert property ( // R7
        mode != tpm_pkg::TPM_MODE_16BIT && upper_sel == tpm_pkg::TPM_UCLK_PRESCALE_TAP_256
        |=> upper_en_q == $past(tap_256))
        else $error("upper enable does not follow tap 256");
    cov_cascade: cover property (mode == tpm_pkg::TPM_MODE_16BIT && lower_ovf ##1 upper_en_q);

endmodule
`default_nettype wire

//--- rtl/tpm_flop.sv
`timescale 1ns/1ps
`default_nettype none
module tpm_flop (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Direct action
    input  wire logic       act_we,
    input  wire logic [1:0] act_code,
    // Automatic toggle
    input  wire logic       toggle_en,
    input  wire logic       toggle_src,
    input  wire logic [1:0] pair01_mode,
    input  wire logic       timer0_pulse,
    input  wire logic       timer1_pulse,
    // Flip-flop
    output logic            flop_q
);

    logic flop_d;
    logic toggle_hit;

    // ----------------------------------------
    // Toggle source
    // ----------------------------------------
    // R9: selected timer toggles
    // R10: source only in 8-bit mode
    assign toggle_hit = toggle_en &&
        ((pair01_mode == tpm_pkg::TPM_MODE_8BIT) ? (toggle_src ? timer1_pulse : timer0_pulse)
                                                  : timer1_pulse);

    // R8: direct action decode
    // R13: one action per write
    always_comb begin
        flop_d = flop_q;
        if (toggle_hit) begin
            flop_d = ~flop_q;
        end
        if (act_we) begin
            case (act_code)
                tpm_pkg::TPM_FF_INVERT: flop_d = ~flop_q;
                tpm_pkg::TPM_FF_SET:    flop_d = 1'b1;
                tpm_pkg::TPM_FF_CLEAR:  flop_d = 1'b0;
                default:                flop_d = flop_d;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flop_q <= tpm_pkg::TPM_FLOP_RST;
        end else begin
            flop_q <= flop_d;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_flop_set: assert property ( // R8
        act_we && act_code == tpm_pkg::TPM_FF_SET |=> flop_q)
        else $error("set action did not set flop");
    chk_flop_clear: assert property ( // R8
        act_we && act_code == tpm_pkg::TPM_FF_CLEAR |=> !flop_q)
        else $error("clear action did not clear flop");
    chk_flop_invert: assert property ( // R13
        act_we && act_code == tpm_pkg::TPM_FF_INVERT |=> flop_q != $past(flop_q))
        else $error("invert action did not invert flop");
    chk_auto_toggle: assert property ( // R9
        !act_we && toggle_en && pair01_mode == tpm_pkg::TPM_MODE_8BIT &&
        (toggle_src ? timer1_pulse : timer0_pulse) |=> flop_q != $past(flop_q))
        else $error("selected timer did not toggle flop");
    chk_toggle_off: assert property ( // R9
        !act_we && !toggle_en |=> $stable(flop_q))
        else $error("flop moved with toggle disabled");
    chk_src_ignored: assert property ( // R10
        !act_we && toggle_en && pair01_mode != tpm_pkg::TPM_MODE_8BIT && !timer1_pulse
        |=> $stable(flop_q))
        else $error("source select used outside 8-bit mode");
    cov_toggle: cover property (toggle_hit && !act_we ##1 toggle_hit && !act_we);
    cov_set_then_toggle: cover property (act_we && act_code == tpm_pkg::TPM_FF_SET ##1 toggle_hit);

endmodule
`default_nettype wire

//--- test/tpm_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin mismatches++; $display("CHECK FAILED %s exp %h seen %h", n, e, s); end end
module tpm_top_tb_top;
    logic            clk = 1'b0;
    logic            sys_rst = 1'b1;
    logic [11:0]     s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]     s_axi_wdata = '0;
    logic [3:0]      s_axi_wstrb = '0;
    logic            s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic            prescale_tap_1 = 0, prescale_tap_4 = 0, prescale_tap_16 = 0, prescale_tap_256 = 0;
    logic            ext_count_input_four = 0, timer_unit_zero = 0, timer_unit_one = 0;
    logic [1:0]      lower_match_pulse = '0, lower_ovf_pulse = '0, pair01_mode = '0;
    logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_flop_one;
    logic [1:0]      s_axi_bresp, s_axi_rresp, lower_count_en, upper_count_en;
    logic [1:0]      pair_split_q, pair_cascade_q, pair_ppg_q, pair_pwm_q;
    logic [31:0]     s_axi_rdata;
    logic [1:0][8:0] pwm_period_q;
    int              mismatches = 0, comparisons = 0;
    logic [1:0]      qb [$];
    logic [65:0]     qr [$];
    logic [65:0]     rq;
    logic [1:0]      bq, e;
    logic [8:0]      samp = '0, plen;
    logic [7:0]      cfg [2] = '{8'h00, 8'h00};
    logic [7:0]      c;
    bit              chk_on = 0, rnd_on = 0;
    logic [11:0]     ftab [13] = '{12'h041, 12'h080, 12'h001, 12'h000, 12'h0C0, 12'h0E5, 12'h0E9,
                                   12'h0F8, 12'h0F4, 12'h0EB, 12'h0E7, 12'h06A, 12'h0CA};

    always #20 clk = ~clk;

    tpm_top tpm_top_inst (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .prescale_tap_1, .prescale_tap_4, .prescale_tap_16, .prescale_tap_256,
        .ext_count_input_four, .lower_match_pulse, .lower_ovf_pulse, .pair01_mode, .timer_unit_zero,
        .timer_unit_one, .lower_count_en, .upper_count_en, .pair_split_q, .pair_cascade_q, .pair_ppg_q,
        .pair_pwm_q, .pwm_period_q, .timer_flop_one);

    function automatic logic [1:0] exp_en(logic [7:0] k, bit p, logic [8:0] s);
        logic l, u;
        case (k[1:0])
            2'b00: l = p ? 1'b0 : s[0];
            2'b01: l = s[1];
            2'b10: l = s[2];
            default: l = s[3];
        endcase
        case (k[3:2])
            2'b00: u = s[5+p];
            2'b01: u = s[1];
            2'b10: u = s[3];
            default: u = s[4];
        endcase
        if (k[7:6] == 2'b01) u = s[7+p];
        return {u, l};
    endfunction

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 200) begin
            mismatches++;
            finish_test();
        end
    endtask

    task automatic axi_wr(logic [9:0] i, logic [7:0] d, logic [3:0] st, logic [1:0] rs);
        int n;
        bit a, w;
        n = 0; a = 0; w = 0;
        qb.push_back(rs);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'($urandom), d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(a && w)) begin
            tick(n);
            if (!a && s_axi_awready) begin a = 1; s_axi_awvalid <= 1'b0; end
            if (!w && s_axi_wready) begin w = 1; s_axi_wvalid <= 1'b0; end
        end
        s_axi_bready <= 1'b1;
        do tick(n); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(logic [9:0] i, logic [31:0] d, logic [1:0] rs);
        int n;
        n = 0;
        qr.push_back({(i == tpm_pkg::TPM_IDX_FLOP1) ? 32'hFFFF_FF8F : 32'hFFFF_FFFF, d, rs});
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        do tick(n); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do tick(n); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    always @(posedge clk) begin
        samp <= {lower_ovf_pulse, lower_match_pulse, prescale_tap_256, prescale_tap_16, prescale_tap_4,
                 prescale_tap_1, ext_count_input_four};
        if (rnd_on) begin
            {prescale_tap_1, prescale_tap_4, prescale_tap_16, prescale_tap_256} <= 4'($urandom);
            {ext_count_input_four, lower_match_pulse, lower_ovf_pulse} <= 5'($urandom);
        end
    end

    // Results seen on the bus against the oldest note
    always @(posedge clk) begin
        if (s_axi_bvalid && s_axi_bready && qb.size() > 0) begin
            bq = qb.pop_front();
            `CHK("bresp", bq, s_axi_bresp)
        end
        if (s_axi_rvalid && s_axi_rready && qr.size() > 0) begin
            rq = qr.pop_front();
            `CHK("rdata", rq[33:2], s_axi_rdata & rq[65:34])
            `CHK("rresp", rq[1:0], s_axi_rresp)
        end
    end

    always @(negedge clk) if (chk_on) for (int p = 0; p < 2; p++) begin
        e = exp_en(cfg[p], p[0], samp);
        `CHK("lower_en", e[0], lower_count_en[p])
        `CHK("upper_en", e[1], upper_count_en[p])
    end

    initial begin
        void'($urandom(60219));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        axi_rd(tpm_pkg::TPM_IDX_FLOP1, 32'h0000_000C, tpm_pkg::TPM_RESP_OKAY);
        axi_rd(tpm_pkg::TPM_IDX_P45, 32'h0000_0000, tpm_pkg::TPM_RESP_OKAY);
        axi_rd(tpm_pkg::TPM_IDX_P67, 32'h0000_0000, tpm_pkg::TPM_RESP_OKAY);
        axi_wr(10'h100, 8'h55, 4'h1, tpm_pkg::TPM_RESP_SLVERR);
        axi_rd(10'h100, 32'h0000_0000, tpm_pkg::TPM_RESP_SLVERR);
        rnd_on = 1;
        chk_on = 1;
        for (int p = 0; p < 2; p++) for (int m = 0; m < 4; m++) for (int pw = 0; pw < 4; pw++) begin
            c = {m[1:0], pw[1:0] | 2'(m == 3 && !pw), 2'($urandom), p ? 2'(1 + $urandom % 3) : 2'($urandom)};
            chk_on = 0;
            axi_wr(p ? tpm_pkg::TPM_IDX_P67 : tpm_pkg::TPM_IDX_P45, c, 4'h1, tpm_pkg::TPM_RESP_OKAY);
            repeat (2) @(posedge clk);
            cfg[p] = c;
            chk_on = 1;
            repeat (20) @(posedge clk);
            plen = (m != 3) ? tpm_pkg::TPM_PLEN_0 : (pw < 2) ? tpm_pkg::TPM_PLEN_64 :
                   (pw == 2) ? tpm_pkg::TPM_PLEN_128 : tpm_pkg::TPM_PLEN_256;
            `CHK("split", m == 0, pair_split_q[p])
            `CHK("cascade", m == 1, pair_cascade_q[p])
            `CHK("ppg", m == 2, pair_ppg_q[p])
            `CHK("pwm", m == 3, pair_pwm_q[p])
            `CHK("period", plen, pwm_period_q[p])
            axi_rd(p ? tpm_pkg::TPM_IDX_P67 : tpm_pkg::TPM_IDX_P45, {24'h0000_00, c}, tpm_pkg::TPM_RESP_OKAY);
        end
        axi_wr(tpm_pkg::TPM_IDX_P45, 8'hFF, 4'h0, tpm_pkg::TPM_RESP_OKAY);
        axi_rd(tpm_pkg::TPM_IDX_P45, {24'h0000_00, cfg[0]}, tpm_pkg::TPM_RESP_OKAY);
        for (int k = 0; k < 13; k++) begin
            pair01_mode <= {1'b0, ftab[k][1]};
            axi_wr(tpm_pkg::TPM_IDX_FLOP1, ftab[k][11:4], 4'h1, tpm_pkg::TPM_RESP_OKAY);
            timer_unit_zero <= ftab[k][2];
            timer_unit_one <= ftab[k][3];
            @(posedge clk);
            timer_unit_zero <= 1'b0;
            timer_unit_one <= 1'b0;
            repeat (2) @(posedge clk);
            `CHK("flop", ftab[k][0], timer_flop_one)
            axi_rd(tpm_pkg::TPM_IDX_FLOP1, {28'h000_0000, ftab[k][7:4]}, tpm_pkg::TPM_RESP_OKAY);
        end
        finish_test();
    end
endmodule
`default_nettype wire
